// [common/txpc_defines.vh]
`ifndef TXPC_DEFINES_VH
`define TXPC_DEFINES_VH

// register byte addresses
`define TXPC_ADDR_CTRL        8'h00
`define TXPC_ADDR_SPACING     8'h04
`define TXPC_ADDR_IRQ_STATUS  8'h08
`define TXPC_ADDR_IRQ_CLEAR   8'h0C
`define TXPC_ADDR_IRQ_ENABLE  8'h10
`define TXPC_ADDR_GOOD_PKTS   8'h14
`define TXPC_ADDR_BAD_FCS     8'h18
`define TXPC_ADDR_BYTES       8'h1C
`define TXPC_ADDR_STATE       8'h20
`define TXPC_ADDR_MARKER_BASE 8'h40
`define TXPC_ADDR_MARKER_LAST 8'h5C

// control register fields
`define TXPC_CTRL_PCS_RESET   0
`define TXPC_CTRL_FCS_INS     1
`define TXPC_CTRL_IGNORE_FCS  2
`define TXPC_CTRL_CUSTOM_PRE  3
`define TXPC_CTRL_RSFEC50     4
`define TXPC_CTRL_WIDTH       5
`define TXPC_CTRL_RESET       5'h03

// interrupt status fields
`define TXPC_IRQ_BAD_FCS      0
`define TXPC_IRQ_UNDERFLOW    1
`define TXPC_IRQ_OVERFLOW     2
`define TXPC_IRQ_PKT_DONE     3
`define TXPC_IRQ_WIDTH        4

// marker spacing
`define TXPC_SPACING_DEFAULT  16'h3FFF
`define TXPC_SPACING_RSFEC50  16'h4FFF
`define TXPC_LANE_COUNT       4
`define TXPC_MARKER_RESET     64'h0000000000000000

// framing bytes and fcs constants
`define TXPC_PREAMBLE_BYTE    8'h55
`define TXPC_SFD_BYTE         8'hD5
`define TXPC_PREAMBLE_LEN     3'h7
`define TXPC_FCS_LEN          2'h3
`define TXPC_CRC_INIT         32'hFFFFFFFF
`define TXPC_CRC_POLY         32'hEDB88320
`define TXPC_CRC_RESIDUE      32'hDEBB20E3

`endif

// [hdl/txpc_crc32.v]
`default_nettype none

// running fcs accumulator, one byte per enabled cycle
module txpc_crc32 (
  // clock, reset and enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // control and data
  input  wire        init,
  input  wire        en,
  input  wire [7:0]  data,
  // running value
  output reg  [31:0] crc_reg
);

`include "txpc_defines.vh"

  reg [31:0] crc_next;
  integer    i;

  // bitwise reflected update of one byte
  always @* begin
    crc_next = crc_reg;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_next[0] ^ data[i]) begin
        crc_next = (crc_next >> 1) ^ `TXPC_CRC_POLY;
      end else begin
        crc_next = crc_next >> 1;
      end
    end
  end

  // init wins over update so a new packet always starts clean
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= `TXPC_CRC_INIT;
    end else if (ce) begin
      if (init) begin
        crc_reg <= `TXPC_CRC_INIT;
      end else if (en) begin
        crc_reg <= crc_next;
      end
    end
  end

endmodule

`default_nettype wire

// [hdl/txpc_top.v]
// Behaviour
// RQ1: ignore control acts only without fcs insertion
// RQ2: bad fcs not counted good when ignore low
// RQ3: bad fcs counted good when ignore high
// RQ4: bad fcs flagged, stomped, frame sent unchanged
// RQ5: other statistics treat bad frame as clean
// RQ6: markers every spacing setting plus one words
// RQ7: software programs spacing 16383 normally
// RQ8: rs-fec 50g forces spacing to 20479
// RQ9: separate 64-bit marker value per lane
// RQ10: software changes markers only during reset
// RQ11: local fault high while encoder initialising
// RQ12: custom preamble replaces standard preamble
// RQ13: user gives preamble with start of packet
// RQ14: underflow on empty read, overflow on full write
// RQ15: fifo flags exist in this wide variant
// RQ16: fcs appended only when insertion enabled
// RQ17: preamble settings captured per packet start
`default_nettype none

module txpc_top (
  // clock, reset, enable
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  // register port
  input  wire [7:0]   reg_addr,
  input  wire [31:0]  reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [31:0]  reg_rdata,
  // user transmit stream
  input  wire [7:0]   tx_data,
  input  wire         tx_valid,
  input  wire         tx_sop,
  input  wire         tx_eop,
  input  wire [55:0]  tx_preamble_in,
  output reg          tx_ready,
  // line side byte stream
  output reg  [7:0]   line_data,
  output reg          line_valid,
  output reg          line_last,
  // lane markers
  output reg  [63:0]  lane_marker_data,
  output reg  [1:0]   lane_marker_lane,
  output reg          lane_marker_valid,
  // status
  output reg          stat_tx_local_fault,
  output reg          stat_tx_bad_fcs,
  output reg          stomped_fcs,
  output reg          stat_tx_underflow_err,
  output reg          stat_tx_overflow_err,
  output reg          irq
);

`include "txpc_defines.vh"

  // encoder states
  localparam [4:0] ST_INIT = 5'h01;
  localparam [4:0] ST_IDLE = 5'h02;
  localparam [4:0] ST_PRE  = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_FCS  = 5'h10;

  reg  [`TXPC_CTRL_WIDTH-1:0] ctrl_reg;
  reg  [15:0]                 spacing_reg;
  reg  [`TXPC_IRQ_WIDTH-1:0]  irq_status_reg;
  reg  [`TXPC_IRQ_WIDTH-1:0]  irq_enable_reg;
  reg  [31:0]                 good_pkts_reg;
  reg  [31:0]                 bad_fcs_cnt_reg;
  reg  [31:0]                 bytes_reg;
  reg  [63:0]                 marker_reg [0:`TXPC_LANE_COUNT-1];
  reg  [4:0]                  state_reg;
  reg  [4:0]                  state_next;
  reg  [2:0]                  idx_reg;
  reg  [55:0]                 pre_reg;
  reg                         pre_custom_reg;
  reg                         fcs_ins_reg;
  reg                         take_last_reg;
  reg  [15:0]                 word_cnt_reg;
  reg  [1:0]                  lane_reg;
  reg  [`TXPC_IRQ_WIDTH-1:0]  irq_event;
  reg  [31:0]                 rd_value;
  wire [31:0]                 crc_val;
  wire                        pcs_reset;
  wire                        take;
  wire                        take_last;
  wire                        frame_bad;
  wire                        start_pkt;
  wire [15:0]                 spacing_eff;
  wire [3:0]                  mk_index;
  integer                     k;

  assign pcs_reset = ctrl_reg[`TXPC_CTRL_PCS_RESET];
  assign take      = (state_reg == ST_DATA) && tx_ready && tx_valid;
  assign take_last = take && tx_eop;
  assign start_pkt = (state_reg == ST_IDLE) && tx_valid && tx_sop;
  // check residue over frame including user fcs
  assign frame_bad = !fcs_ins_reg && (crc_val != `TXPC_CRC_RESIDUE);
  // rs-fec in 50g overrides the programmed spacing
  assign spacing_eff = ctrl_reg[`TXPC_CTRL_RSFEC50] ? `TXPC_SPACING_RSFEC50 : spacing_reg; // RQ8
  assign mk_index    = reg_addr[5:2];

  // fcs over user bytes, cleared at packet start
  txpc_crc32 u_crc (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .init    (start_pkt),
    .en      (take),
    .data    (tx_data),
    .crc_reg (crc_val)
  );

  // register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg       <= `TXPC_CTRL_RESET;
      spacing_reg    <= `TXPC_SPACING_DEFAULT;
      irq_enable_reg <= {`TXPC_IRQ_WIDTH{1'b0}};
      for (k = 0; k < `TXPC_LANE_COUNT; k = k + 1) begin
        marker_reg[k] <= `TXPC_MARKER_RESET;
      end
    end else if (ce && reg_wr) begin
      if (reg_addr == `TXPC_ADDR_CTRL) begin
        ctrl_reg <= reg_wdata[`TXPC_CTRL_WIDTH-1:0];
      end else if (reg_addr == `TXPC_ADDR_SPACING) begin
        spacing_reg <= reg_wdata[15:0]; // RQ6
      end else if (reg_addr == `TXPC_ADDR_IRQ_ENABLE) begin
        irq_enable_reg <= reg_wdata[`TXPC_IRQ_WIDTH-1:0];
      end else if (reg_addr >= `TXPC_ADDR_MARKER_BASE && reg_addr <= `TXPC_ADDR_MARKER_LAST) begin
        // even word is low half, odd word high half of a lane marker
        if (mk_index[0]) begin
          marker_reg[mk_index[2:1]][63:32] <= reg_wdata; // RQ9
        end else begin
          marker_reg[mk_index[2:1]][31:0] <= reg_wdata; // RQ9
        end
      end
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    rd_value = 32'h00000000;
    if (reg_addr == `TXPC_ADDR_CTRL) begin
      rd_value = {27'h0, ctrl_reg};
    end else if (reg_addr == `TXPC_ADDR_SPACING) begin
      rd_value = {16'h0000, spacing_reg};
    end else if (reg_addr == `TXPC_ADDR_IRQ_STATUS) begin
      rd_value = {28'h0000000, irq_status_reg};
    end else if (reg_addr == `TXPC_ADDR_IRQ_ENABLE) begin
      rd_value = {28'h0000000, irq_enable_reg};
    end else if (reg_addr == `TXPC_ADDR_GOOD_PKTS) begin
      rd_value = good_pkts_reg;
    end else if (reg_addr == `TXPC_ADDR_BAD_FCS) begin
      rd_value = bad_fcs_cnt_reg;
    end else if (reg_addr == `TXPC_ADDR_BYTES) begin
      rd_value = bytes_reg;
    end else if (reg_addr == `TXPC_ADDR_STATE) begin
      rd_value = {22'h0, lane_reg, 3'h0, state_reg};
    end else if (reg_addr >= `TXPC_ADDR_MARKER_BASE && reg_addr <= `TXPC_ADDR_MARKER_LAST) begin
      if (mk_index[0]) begin
        rd_value = marker_reg[mk_index[2:1]][63:32];
      end else begin
        rd_value = marker_reg[mk_index[2:1]][31:0];
      end
    end
  end

  // read data stands one cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_value : 32'h00000000;
    end
  end

  // encoder next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: begin
        if (!pcs_reset) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (start_pkt) begin
          state_next = ST_PRE;
        end
      end
      ST_PRE: begin
        if (idx_reg == `TXPC_PREAMBLE_LEN) begin
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (take_last) begin
          state_next = fcs_ins_reg ? ST_FCS : ST_IDLE; // RQ16
        end
      end
      ST_FCS: begin
        if (idx_reg[1:0] == `TXPC_FCS_LEN) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
    if (pcs_reset) begin
      state_next = ST_INIT;
    end
  end

  // encoder datapath and line output
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= ST_INIT;
      idx_reg             <= 3'h0;
      pre_reg             <= 56'h00000000000000;
      pre_custom_reg      <= 1'b0;
      fcs_ins_reg         <= 1'b1;
      tx_ready            <= 1'b0;
      line_data           <= 8'h00;
      line_valid          <= 1'b0;
      line_last           <= 1'b0;
      stat_tx_local_fault <= 1'b1;
    end else if (ce) begin
      state_reg           <= state_next;
      stat_tx_local_fault <= (state_next == ST_INIT); // RQ11
      tx_ready            <= (state_next == ST_DATA) && !take_last;
      line_valid          <= 1'b0;
      line_last           <= 1'b0;
      idx_reg             <= (state_next == state_reg) ? idx_reg + 3'h1 : 3'h0;
      if (start_pkt) begin
        // captured once per packet, held for its whole length
        pre_reg        <= tx_preamble_in; // RQ13 RQ17
        pre_custom_reg <= ctrl_reg[`TXPC_CTRL_CUSTOM_PRE]; // RQ17
        fcs_ins_reg    <= ctrl_reg[`TXPC_CTRL_FCS_INS];
      end
      if (state_reg == ST_PRE) begin
        line_valid <= 1'b1;
        if (idx_reg == `TXPC_PREAMBLE_LEN) begin
          line_data <= `TXPC_SFD_BYTE;
        end else if (pre_custom_reg) begin
          line_data <= pre_reg[idx_reg*8 +: 8]; // RQ12
        end else begin
          line_data <= `TXPC_PREAMBLE_BYTE;
        end
      end else if (take) begin
        // user bytes go out untouched, even with a bad fcs
        line_data  <= tx_data; // RQ4
        line_valid <= 1'b1;
        line_last  <= tx_eop && !fcs_ins_reg;
      end else if (state_reg == ST_FCS) begin
        line_data  <= ~crc_val[idx_reg[1:0]*8 +: 8]; // RQ16
        line_valid <= 1'b1;
        line_last  <= (idx_reg[1:0] == `TXPC_FCS_LEN);
      end
    end
  end

  // end of packet statistics and fcs flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      good_pkts_reg         <= 32'h00000000;
      bad_fcs_cnt_reg       <= 32'h00000000;
      bytes_reg             <= 32'h00000000;
      stat_tx_bad_fcs       <= 1'b0;
      stomped_fcs           <= 1'b0;
      stat_tx_underflow_err <= 1'b0;
      stat_tx_overflow_err  <= 1'b0;
      take_last_reg         <= 1'b0;
    end else if (ce) begin
      stat_tx_bad_fcs       <= 1'b0;
      stomped_fcs           <= 1'b0;
      // empty read: stream ran dry inside a packet
      stat_tx_underflow_err <= (state_reg == ST_DATA) && tx_ready && !tx_valid; // RQ14 RQ15
      // full write: data offered while the path cannot take it
      stat_tx_overflow_err  <= tx_valid && !tx_ready && !start_pkt; // RQ14 RQ15
      if (take) begin
        bytes_reg <= bytes_reg + 32'h00000001; // RQ5
      end
      // verdict a cycle after the last byte, once the crc has taken it in
      take_last_reg <= take_last;
      if (take_last_reg) begin
        // frame_bad is only ever set without insertion
        stat_tx_bad_fcs <= frame_bad; // RQ4
        stomped_fcs     <= frame_bad; // RQ4
        if (frame_bad) begin
          bad_fcs_cnt_reg <= bad_fcs_cnt_reg + 32'h00000001;
        end
        if (!frame_bad || ctrl_reg[`TXPC_CTRL_IGNORE_FCS]) begin
          good_pkts_reg <= good_pkts_reg + 32'h00000001; // RQ1 RQ2 RQ3 RQ5
        end
      end
    end
  end

  // lane marker spacing and per-lane values
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_cnt_reg      <= 16'h0000;
      lane_reg          <= 2'h0;
      lane_marker_data  <= 64'h0000000000000000;
      lane_marker_lane  <= 2'h0;
      lane_marker_valid <= 1'b0;
    end else if (ce) begin
      lane_marker_valid <= 1'b0;
      if (pcs_reset) begin
        // settings may only move while held here
        word_cnt_reg <= 16'h0000; // RQ10
        lane_reg     <= 2'h0;
      end else if (word_cnt_reg == spacing_eff) begin
        word_cnt_reg      <= 16'h0000; // RQ6
        lane_marker_data  <= marker_reg[lane_reg]; // RQ9
        lane_marker_lane  <= lane_reg;
        lane_marker_valid <= 1'b1;
        lane_reg          <= lane_reg + 2'h1;
      end else begin
        word_cnt_reg <= word_cnt_reg + 16'h0001;
      end
    end
  end

  // sticky interrupt status, a new event wins over a clear
  always @* begin
    irq_event = {`TXPC_IRQ_WIDTH{1'b0}};
    irq_event[`TXPC_IRQ_BAD_FCS]   = take_last_reg && frame_bad;
    irq_event[`TXPC_IRQ_UNDERFLOW] = (state_reg == ST_DATA) && tx_ready && !tx_valid;
    irq_event[`TXPC_IRQ_OVERFLOW]  = tx_valid && !tx_ready && !start_pkt;
    irq_event[`TXPC_IRQ_PKT_DONE]  = take_last;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= {`TXPC_IRQ_WIDTH{1'b0}};
      irq            <= 1'b0;
    end else if (ce) begin
      if (reg_wr && reg_addr == `TXPC_ADDR_IRQ_CLEAR) begin
        irq_status_reg <= (irq_status_reg & ~reg_wdata[`TXPC_IRQ_WIDTH-1:0]) | irq_event;
      end else begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

endmodule

`default_nettype wire

// [tb/txpc_assertions.sv]
`default_nettype none
// port level checks on the transmit path block
module txpc_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // user stream and line side
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_sop,
  input wire logic       tx_eop,
  input wire logic       tx_ready,
  input wire logic [7:0] line_data,
  input wire logic       line_valid,
  input wire logic       line_last,
  // markers and status
  input wire logic       lane_marker_valid,
  input wire logic       stat_tx_local_fault,
  input wire logic       stat_tx_bad_fcs,
  input wire logic       stomped_fcs,
  input wire logic       stat_tx_underflow_err,
  input wire logic       stat_tx_overflow_err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // both error flags fire together, only after a taken end of packet
  flag_pair_a: assert property (stat_tx_bad_fcs == stomped_fcs)
    else $error("error flags differ");
  flag_cause_a: assert property (stat_tx_bad_fcs |-> $past(tx_valid && tx_ready && tx_eop, 2))
    else $error("error flag without packet end");
  // taken bytes reach the line unchanged one cycle later
  byte_pass_a: assert property (tx_valid && tx_ready |=> line_valid && line_data == $past(tx_data))
    else $error("byte altered or lost");
  frame_end_a: assert property (tx_valid && tx_ready && tx_eop |-> ##[1:5] line_last)
    else $error("frame end missing");
  // eight preamble and delimiter bytes precede the first data byte
  pre_len_a: assert property ($rose(tx_ready) |-> $past(tx_valid && tx_sop, 9))
    else $error("preamble length wrong");
  fault_quiet_a: assert property (stat_tx_local_fault |-> !tx_ready && !line_valid)
    else $error("traffic while initialising");
  under_cause_a: assert property (stat_tx_underflow_err |-> $past(tx_ready && !tx_valid))
    else $error("underflow without starved read");
  over_cause_a: assert property (stat_tx_overflow_err |-> $past(tx_valid && !tx_ready))
    else $error("overflow without refused write");
  marker_pulse_a: assert property (lane_marker_valid |=> !lane_marker_valid)
    else $error("marker strobe too long");
  // main scenarios reached
  cover property (lane_marker_valid);
  cover property (stat_tx_bad_fcs);
  cover property (stat_tx_underflow_err);
  cover property (stat_tx_overflow_err);
endmodule

bind txpc_top txpc_checker u_chk (
  .clk(clk), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid), .tx_sop(tx_sop), .tx_eop(tx_eop),
  .tx_ready(tx_ready), .line_data(line_data), .line_valid(line_valid), .line_last(line_last),
  .lane_marker_valid(lane_marker_valid), .stat_tx_local_fault(stat_tx_local_fault),
  .stat_tx_bad_fcs(stat_tx_bad_fcs), .stomped_fcs(stomped_fcs),
  .stat_tx_underflow_err(stat_tx_underflow_err), .stat_tx_overflow_err(stat_tx_overflow_err)
);
`default_nettype wire

// [tb/txpc_user_src.sv]
`default_nettype none
// user logic feeding frames into the device
module txpc_user_src (
  // clock
  input  wire logic        clk,
  // user stream
  output var  logic [7:0]  tx_data,
  output var  logic        tx_valid,
  output var  logic        tx_sop,
  output var  logic        tx_eop,
  output var  logic [55:0] tx_preamble_in,
  input  wire logic        tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] frm [64];
  // lines start idle
  initial begin
    tx_data = 8'hA5;
    tx_valid = 1'b0;
    tx_sop = 1'b0;
    tx_eop = 1'b0;
    tx_preamble_in = 56'h0;
  end
  // one frame; hold keeps valid up in the preamble, gap starves one cycle
  task automatic send(input int len, input bit hold, input int gap, input logic [55:0] pre);
    int i;
    int k;
    bit tk;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_sop <= 1'b1;
    tx_data <= frm[0];
    tx_preamble_in <= pre;
    @(posedge clk);
    tx_valid <= hold;
    tx_data <= hold ? frm[0] : ~frm[0];
    tx_preamble_in <= ~pre;
    repeat (8) @(posedge clk);
    tx_valid <= 1'b1;
    tx_data <= frm[0];
    i = 0;
    for (k = 0; k < 400 && i < len; k++) begin
      @(negedge clk);
      tk = tx_ready && tx_valid;
      @(posedge clk);
      if (tk) i++;
      tx_sop <= tx_sop && !tk;
      tx_valid <= i < len && !(tk && i == gap);
      tx_eop <= i == len - 1;
      tx_data <= i < len ? frm[i] : ~frm[len - 1];
    end
  endtask
endmodule
`default_nettype wire

// [tb/txpc_top_bench.sv]
`default_nettype none
// self checking bench for the transmit path block
module txpc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [31:0] rdata;
  wire  [55:0] pre_w;
  wire  [63:0] mk_data;
  wire  [7:0]  tx_data, line_data;
  wire  [1:0]  mk_lane;
  wire         tx_valid, tx_sop, tx_eop, tx_ready, line_valid, line_last, mk_v;
  wire         fault, bad_f, stomp, under, over, irq;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc, last_m, sp, nbad, good, badc, bytes;
  logic [1:0]  pl;
  logic [15:0] seed = 16'h002B;
  logic [63:0] mk [4];
  logic [7:0]  cap [$];
  logic [31:0] d;
  logic [3:0]  ctl_t [7] = '{4'h2, 4'h6, 4'h0, 4'h0, 4'h4, 4'hA, 4'h2};
  bit          bad_t [7] = '{0, 0, 0, 1, 1, 0, 0};
  bit          done;

  txpc_top dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .tx_data(tx_data), .tx_valid(tx_valid), .tx_sop(tx_sop),
    .tx_eop(tx_eop), .tx_preamble_in(pre_w), .tx_ready(tx_ready), .line_data(line_data),
    .line_valid(line_valid), .line_last(line_last), .lane_marker_data(mk_data), .lane_marker_lane(mk_lane),
    .lane_marker_valid(mk_v), .stat_tx_local_fault(fault), .stat_tx_bad_fcs(bad_f), .stomped_fcs(stomp),
    .stat_tx_underflow_err(under), .stat_tx_overflow_err(over), .irq(irq)
  );
  txpc_user_src u_src (
    .clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_sop(tx_sop), .tx_eop(tx_eop),
    .tx_preamble_in(pre_w), .tx_ready(tx_ready)
  );

  // 125 MHz clock
  always #4 clk = ~clk;

  // random source and reflected crc register
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] crc(input logic [7:0] b [$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return c;
  endfunction

  // compare, verdict and register cycles
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // line capture, error flags and marker watch
  always @(negedge clk) begin
    cyc++;
    if (line_valid) cap.push_back(line_data);
    if (line_last) done = 1;
    if (bad_f) nbad++;
    if (mk_v) begin
      chk(mk_data, mk[mk_lane], "marker value");
      if (last_m > 0) chk({62'h0, mk_lane}, {62'h0, pl + 2'd1}, "lane order");
      if (last_m > 0 && sp > 0) chk(cyc - last_m, sp + 1, "marker spacing");
      last_m = cyc;
      pl = mk_lane;
    end
  end

  // one frame in mode m, then line bytes, counters and status
  task automatic frame(input int m, input bit h);
    logic [7:0]  e [$];
    logic [7:0]  p [$];
    logic [31:0] c;
    logic [55:0] pre;
    logic [3:0]  t;
    int          i;
    t = ctl_t[m];
    seed = lf(seed);
    pre = {seed, seed, seed, seed[7:0]};
    repeat (8 + seed[3:0]) begin
      seed = lf(seed);
      p.push_back(seed[7:0]);
    end
    c = ~crc(p);
    if (!t[1]) for (i = 0; i < 4; i++) p.push_back(c[8*i+:8] ^ {7'h0, bad_t[m] && i == 0});
    for (i = 0; i < 7; i++) e.push_back(t[3] ? pre[8*i+:8] : 8'h55);
    e.push_back(8'hD5);
    foreach (p[j]) e.push_back(p[j]);
    if (t[1]) for (i = 0; i < 4; i++) e.push_back(c[8*i+:8]);
    foreach (p[j]) u_src.frm[j] = p[j];
    wr(8'h00, {28'h0, t});
    cap.delete();
    done = 0;
    u_src.send(p.size(), h, h ? 3 : 99, pre);
    for (i = 0; i < 300 && !done; i++) @(negedge clk);
    if (!done) begin
      failures++;
      $display("ERROR %0t frame end timeout", $time);
    end
    chk(cap.size(), e.size(), "frame length");
    foreach (e[j]) chk(cap[j], e[j], "line byte");
    bytes += p.size();
    if (!bad_t[m] || (t[2] && !t[1])) good++;
    if (bad_t[m]) badc++;
    repeat (2) @(posedge clk);
    rd(8'h14, d); chk(d, good, "good count");
    rd(8'h18, d); chk(d, badc, "bad count");
    rd(8'h1C, d); chk(d, bytes, "byte count");
    chk(nbad, badc, "error flags");
    rd(8'h08, d); chk(d[3:1], {1'b1, h, h}, "status");
    if (!done) results;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, d); chk(d, 32'h3, "control reset");
    chk(fault, 1'b1, "fault in init");
    rd(8'h04, d); chk(d, 32'h3FFF, "spacing reset");
    rd(8'hFC, d); chk(d, 32'h0, "unmapped read");
    wr(8'h04, 32'h000F);
    for (int l = 0; l < 4; l++) begin
      seed = lf(seed);
      mk[l] = {seed, ~seed, seed, lf(seed)};
      wr(8'(8'h40 + 8 * l), mk[l][31:0]);
      wr(8'(8'h44 + 8 * l), mk[l][63:32]);
    end
    sp = 15;
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h2);
    repeat (3) @(negedge clk);
    chk(fault, 1'b0, "fault after init");
    for (int m = 0; m < 7; m++) begin
      frame(m, m == 6);
      if (m == 3) begin
        chk(irq, 1'b1, "irq raised");
        wr(8'h0C, 32'h1);
        wr(8'h10, 32'h0);
        @(negedge clk);
        chk(irq, 1'b0, "irq cleared");
      end
    end
    chk(irq, 1'b0, "irq masked");
    sp = 0;
    wr(8'h00, 32'h11);
    wr(8'h00, 32'h10);
    last_m = 0;
    sp = 20479;
    repeat (41500) @(posedge clk);
    chk(last_m > 0, 1'b1, "fec markers seen");
    results;
  end
endmodule
`default_nettype wire
